// ===== swss_master.sv
// Single-wire bus master: reset/presence, byte transfer and the two overdrive selects.
// Assumes an external pull-up on the line and a user that waits for o_req_ready.
`timescale 1ns/1ps
`default_nettype none
`include "swss_regs.svh"
module swss_master
    import swss_pkg::*;
#(
    parameter int STD_RST_LOW_CYC  = `SWSS_STD_RST_LOW_CYC,
    parameter int STD_RST_HIGH_CYC = `SWSS_STD_RST_HIGH_CYC,
    parameter int STD_PRES_SMP_CYC = `SWSS_STD_PRES_SMP_CYC,
    parameter int STD_W0_LOW_CYC   = `SWSS_STD_W0_LOW_CYC,
    parameter int STD_SLOT_CYC     = `SWSS_STD_SLOT_CYC,
    parameter int OD_RST_LOW_CYC   = `SWSS_OD_RST_LOW_CYC,
    parameter int OD_RST_HIGH_CYC  = `SWSS_OD_RST_HIGH_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_req_valid,
    input  wire swss_op_t    i_req_op,
    input  wire logic [7:0]  i_req_byte,
    input  wire logic [63:0] i_req_rom,
    input  wire logic        i_reset_std,
    output logic             o_req_ready,
    output logic             o_done,
    output logic             o_presence,
    output logic [7:0]       o_rd_byte,
    output logic             o_overdrive,
    input  wire logic        i_line_in,
    output logic             o_line_out,
    output logic             o_line_oe_n
);
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} swss_state_t;

    swss_state_t state_r;
    swss_state_t state_nxt;
    swss_op_t    op_r;
    logic [71:0] sh_r;
    logic [71:0] sh_nxt;
    logic [6:0]  left_r;
    logic [6:0]  left_nxt;
    logic [7:0]  rx_r;
    logic [7:0]  rx_nxt;
    logic        rst_std_r;
    logic        overdrive_flag_r;
    logic        overdrive_nxt;
    logic        ready_r;
    logic        ready_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        presence_r;
    logic        presence_nxt;
    logic [7:0]  rd_byte_r;
    logic [7:0]  rd_byte_nxt;
    logic        line_out_r;
    logic        slot_start;
    logic        slot_done;
    logic        slot_bit;
    logic        slot_fast;
    swss_slot_t  slot_kind;
    logic        is_reset;
    logic        od_arm;
    logic        last_bit;

    // Slot selection from the current op and the next bit to send
    assign is_reset   = (op_r == SWSS_OP_RESET);
    assign slot_start = (state_r == ST_START);
    assign slot_kind  = is_reset                     ? SWSS_SK_RESET :
                        (op_r == SWSS_OP_READ_BYTE)  ? SWSS_SK_READ  :
                        sh_r[0]                      ? SWSS_SK_WRITE1 : SWSS_SK_WRITE0;
    // Standard timing unless in fast mode; a standard reset is forced on request
    // A plain reset after a skip stays fast, so a match can address one slave
    assign slot_fast  = overdrive_flag_r && !(is_reset && rst_std_r);
    // Fast mode is taken once the command byte has gone out
    assign od_arm     = ((op_r == SWSS_OP_OD_SKIP)  && left_r == 7'h01) ||
                        ((op_r == SWSS_OP_OD_MATCH) && left_r == 7'h41);
    assign last_bit   = (left_r == 7'h01);

    // Request sequencer, least significant bit first
    always_comb begin
        state_nxt     = state_r;
        sh_nxt        = sh_r;
        left_nxt      = left_r;
        rx_nxt        = rx_r;
        overdrive_nxt = overdrive_flag_r;
        ready_nxt     = ready_r;
        done_nxt      = 1'b0;
        presence_nxt  = presence_r;
        rd_byte_nxt   = rd_byte_r;
        case (state_r)
            ST_IDLE: begin
                if (i_req_valid && ready_r) begin
                    ready_nxt = 1'b0;
                    state_nxt = ST_START;
                    left_nxt  = 7'h08;
                    case (i_req_op)
                        SWSS_OP_RESET:      left_nxt = 7'h01;
                        SWSS_OP_WRITE_BYTE: sh_nxt   = {64'h0000_0000_0000_0000, i_req_byte};
                        SWSS_OP_OD_SKIP:    sh_nxt   = {64'h0000_0000_0000_0000, `SWSS_CMD_OD_SKIP};
                        SWSS_OP_OD_MATCH: begin
                            sh_nxt   = {i_req_rom, `SWSS_CMD_OD_MATCH};
                            left_nxt = 7'h48;
                        end
                        default:            sh_nxt   = sh_r;
                    endcase
                end
            end
            ST_START: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (slot_done) begin
                    sh_nxt   = {1'b0, sh_r[71:1]};
                    left_nxt = left_r - 7'h01;
                    rx_nxt   = {slot_bit, rx_r[7:1]};
                    if (od_arm) begin
                        overdrive_nxt = 1'b1;      // Identity bits follow at fast speed
                    end
                    if (is_reset) begin
                        presence_nxt = !slot_bit;  // Sampled low means a slave answered
                        if (!slot_fast) begin
                            overdrive_nxt = 1'b0;  // Long reset returns all to standard
                        end
                    end
                    if (last_bit) begin
                        state_nxt = ST_IDLE;
                        ready_nxt = 1'b1;
                        done_nxt  = 1'b1;
                        if (op_r == SWSS_OP_READ_BYTE) begin
                            rd_byte_nxt = {slot_bit, rx_r[7:1]};
                        end
                    end else begin
                        state_nxt = ST_START;      // Next slot only after full recovery
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // Request fields latched at acceptance
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            op_r      <= SWSS_OP_RESET;
            rst_std_r <= 1'b0;
        end else if (state_r == ST_IDLE && i_req_valid && ready_r) begin
            op_r      <= i_req_op;
            rst_std_r <= i_reset_std;
        end
    end

    // Sequencer state and shift data
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            sh_r    <= '0;
            left_r  <= '0;
            rx_r    <= '0;
        end else begin
            state_r <= state_nxt;
            sh_r    <= sh_nxt;
            left_r  <= left_nxt;
            rx_r    <= rx_nxt;
        end
    end

    // User-side outputs; the line data is always low, only the enable moves
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            overdrive_flag_r <= 1'b0;
            ready_r          <= 1'b1;
            done_r           <= 1'b0;
            presence_r       <= 1'b0;
            rd_byte_r        <= '0;
            line_out_r       <= 1'b0;
        end else begin
            overdrive_flag_r <= overdrive_nxt;
            ready_r          <= ready_nxt;
            done_r           <= done_nxt;
            presence_r       <= presence_nxt;
            rd_byte_r        <= rd_byte_nxt;
            line_out_r       <= 1'b0;
        end
    end

    // Waveform timing lives in the slot timer; long counts pass down so tests can shorten them
    swss_slot #(
        .CNT_W            (17),
        .STD_RST_LOW_CYC  (STD_RST_LOW_CYC),
        .STD_RST_HIGH_CYC (STD_RST_HIGH_CYC),
        .STD_PRES_SMP_CYC (STD_PRES_SMP_CYC),
        .STD_W0_LOW_CYC   (STD_W0_LOW_CYC),
        .STD_SLOT_CYC     (STD_SLOT_CYC),
        .OD_RST_LOW_CYC   (OD_RST_LOW_CYC),
        .OD_RST_HIGH_CYC  (OD_RST_HIGH_CYC)
    ) u_slot (
        .i_mclk      (i_mclk),
        .i_rstn      (i_rstn),
        .i_start     (slot_start),
        .i_kind      (slot_kind),
        .i_fast      (slot_fast),
        .i_line_in   (i_line_in),
        .o_line_oe_n (o_line_oe_n),
        .o_done      (slot_done),
        .o_bit       (slot_bit)
    );

    assign o_req_ready = ready_r;
    assign o_done      = done_r;
    assign o_presence  = presence_r;
    assign o_rd_byte   = rd_byte_r;
    assign o_overdrive = overdrive_flag_r;
    assign o_line_out  = line_out_r;
endmodule // swss_master
`default_nettype wire

// ===== swss_regs.svh
// Timing figures, command codes and derived cycle counts for the single-wire bus master.
// Assumes a 125 MHz master clock; every time is in ns and converted to cycles here.
// Operation
// - After overdrive-skip on multidrop, master sends fast reset then match or search.
// - Master makes every falling edge except presence; slave pulls low only in reply.
// - Master samples the line at the presence sample instant after reset release.
// - Reset high window covers presence and recovery; 480us or 48us recommended.
// - Write-one releases before its max low time; write-zero holds past its min.
// - Recovery follows each slot; master waits out the full slot duration.
// - Read init pulse kept short; master samples near but before window end.
// - Line left low past 16us fast or 120us standard resets slaves; idle high.
`ifndef SWSS_REGS_SVH
`define SWSS_REGS_SVH

`define SWSS_CLK_NS          8
`define SWSS_CYC_MIN(t)      (((t) + `SWSS_CLK_NS - 1) / `SWSS_CLK_NS)
`define SWSS_CYC_MAX(t)      ((t) / `SWSS_CLK_NS)

// Command codes
`define SWSS_CMD_OD_SKIP     8'h3C
`define SWSS_CMD_OD_MATCH    8'h69

// Standard speed times, ns
`define SWSS_STD_RST_LOW_NS  480000
`define SWSS_STD_RST_HIGH_NS 480000
`define SWSS_STD_PRES_SMP_NS 70000
`define SWSS_STD_W1_LOW_NS   6000
`define SWSS_STD_W0_LOW_NS   60000
`define SWSS_STD_RD_LOW_NS   6000
`define SWSS_STD_RD_SMP_NS   13000
`define SWSS_STD_SLOT_NS     70000
`define SWSS_STD_REC_NS      10000

// Fast speed times, ns
`define SWSS_OD_RST_LOW_NS   56000
`define SWSS_OD_RST_HIGH_NS  48000
`define SWSS_OD_PRES_SMP_NS  8000
`define SWSS_OD_W1_LOW_NS    1000
`define SWSS_OD_W0_LOW_NS    7500
`define SWSS_OD_RD_LOW_NS    1000
`define SWSS_OD_RD_SMP_NS    2000
`define SWSS_OD_SLOT_NS      10000
`define SWSS_OD_REC_NS       3000

// Cycle counts: least times round up, sample instants (latest) round down
`define SWSS_STD_RST_LOW_CYC  `SWSS_CYC_MIN(`SWSS_STD_RST_LOW_NS)
`define SWSS_STD_RST_HIGH_CYC `SWSS_CYC_MIN(`SWSS_STD_RST_HIGH_NS)
`define SWSS_STD_PRES_SMP_CYC `SWSS_CYC_MAX(`SWSS_STD_PRES_SMP_NS)
`define SWSS_STD_W1_LOW_CYC   `SWSS_CYC_MAX(`SWSS_STD_W1_LOW_NS)
`define SWSS_STD_W0_LOW_CYC   `SWSS_CYC_MIN(`SWSS_STD_W0_LOW_NS)
`define SWSS_STD_RD_LOW_CYC   `SWSS_CYC_MIN(`SWSS_STD_RD_LOW_NS)
`define SWSS_STD_RD_SMP_CYC   `SWSS_CYC_MAX(`SWSS_STD_RD_SMP_NS)
`define SWSS_STD_SLOT_CYC     `SWSS_CYC_MIN(`SWSS_STD_SLOT_NS)
`define SWSS_STD_REC_CYC      `SWSS_CYC_MIN(`SWSS_STD_REC_NS)
`define SWSS_OD_RST_LOW_CYC   `SWSS_CYC_MIN(`SWSS_OD_RST_LOW_NS)
`define SWSS_OD_RST_HIGH_CYC  `SWSS_CYC_MIN(`SWSS_OD_RST_HIGH_NS)
`define SWSS_OD_PRES_SMP_CYC  `SWSS_CYC_MAX(`SWSS_OD_PRES_SMP_NS)
`define SWSS_OD_W1_LOW_CYC    `SWSS_CYC_MAX(`SWSS_OD_W1_LOW_NS)
`define SWSS_OD_W0_LOW_CYC    `SWSS_CYC_MIN(`SWSS_OD_W0_LOW_NS)
`define SWSS_OD_RD_LOW_CYC    `SWSS_CYC_MIN(`SWSS_OD_RD_LOW_NS)
`define SWSS_OD_RD_SMP_CYC    `SWSS_CYC_MAX(`SWSS_OD_RD_SMP_NS)
`define SWSS_OD_SLOT_CYC      `SWSS_CYC_MIN(`SWSS_OD_SLOT_NS)
`define SWSS_OD_REC_CYC       `SWSS_CYC_MIN(`SWSS_OD_REC_NS)

`endif

// ===== swss_pkg.sv
// Types shared by the single-wire bus master and its slot timer.
// Assumes the constants of swss_regs.svh are included by the modules.
package swss_pkg;

    // Requests accepted from the user side
    typedef enum logic [2:0] {
        SWSS_OP_RESET,
        SWSS_OP_WRITE_BYTE,
        SWSS_OP_READ_BYTE,
        SWSS_OP_OD_SKIP,
        SWSS_OP_OD_MATCH
    } swss_op_t;

    // Waveform kinds produced by the slot timer
    typedef enum logic [1:0] {
        SWSS_SK_RESET,
        SWSS_SK_WRITE0,
        SWSS_SK_WRITE1,
        SWSS_SK_READ
    } swss_slot_t;

endpackage

// ===== swss_slot.sv
// Slot timer: produces one reset/presence sequence or one bit slot on the line.
// Assumes i_line_in is asynchronous; it is synchronised here before use.
`timescale 1ns/1ps
`default_nettype none
`include "swss_regs.svh"
module swss_slot
    import swss_pkg::*;
#(
    parameter int CNT_W            = 17,
    parameter int STD_RST_LOW_CYC  = `SWSS_STD_RST_LOW_CYC,
    parameter int STD_RST_HIGH_CYC = `SWSS_STD_RST_HIGH_CYC,
    parameter int STD_PRES_SMP_CYC = `SWSS_STD_PRES_SMP_CYC,
    parameter int STD_W0_LOW_CYC   = `SWSS_STD_W0_LOW_CYC,
    parameter int STD_SLOT_CYC     = `SWSS_STD_SLOT_CYC,
    parameter int OD_RST_LOW_CYC   = `SWSS_OD_RST_LOW_CYC,
    parameter int OD_RST_HIGH_CYC  = `SWSS_OD_RST_HIGH_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       i_start,
    input  wire swss_slot_t i_kind,
    input  wire logic       i_fast,
    input  wire logic       i_line_in,
    output logic            o_line_oe_n,
    output logic            o_done,
    output logic            o_bit
);
    typedef logic [CNT_W-1:0] swss_cnt_t;
    typedef enum logic {SL_IDLE, SL_BUSY} swss_sl_state_t;

    // Per speed end points of each waveform, counted from the falling edge
    localparam swss_cnt_t STD_RST_SMP = CNT_W'(STD_RST_LOW_CYC + STD_PRES_SMP_CYC);
    localparam swss_cnt_t STD_RST_END = CNT_W'(STD_RST_LOW_CYC + STD_RST_HIGH_CYC);
    localparam swss_cnt_t STD_SLT_END = CNT_W'(STD_SLOT_CYC + `SWSS_STD_REC_CYC);
    localparam swss_cnt_t OD_RST_SMP  = CNT_W'(OD_RST_LOW_CYC + `SWSS_OD_PRES_SMP_CYC);
    localparam swss_cnt_t OD_RST_END  = CNT_W'(OD_RST_LOW_CYC + OD_RST_HIGH_CYC);
    localparam swss_cnt_t OD_SLT_END  = CNT_W'(`SWSS_OD_SLOT_CYC + `SWSS_OD_REC_CYC);

    swss_sl_state_t state_r;
    swss_sl_state_t state_nxt;
    swss_cnt_t      cnt_r;
    swss_cnt_t      cnt_nxt;
    swss_slot_t     kind_r;
    logic           fast_r;
    logic           oe_n_r;
    logic           oe_n_nxt;
    logic           done_r;
    logic           done_nxt;
    logic           bit_r;
    logic           bit_nxt;
    logic           line_meta_r;
    logic           line_sync_r;
    swss_cnt_t      low_end;
    swss_cnt_t      smp_at;
    swss_cnt_t      end_at;
    swss_cnt_t      rst_low;

    // Low time per kind and speed; fast figures apply to every waveform
    assign rst_low = fast_r ? CNT_W'(OD_RST_LOW_CYC) : CNT_W'(STD_RST_LOW_CYC);
    assign low_end = (kind_r == SWSS_SK_RESET)  ? rst_low :
                     (kind_r == SWSS_SK_WRITE0) ? (fast_r ? CNT_W'(`SWSS_OD_W0_LOW_CYC)
                                                          : CNT_W'(STD_W0_LOW_CYC)) :
                     (kind_r == SWSS_SK_WRITE1) ? (fast_r ? CNT_W'(`SWSS_OD_W1_LOW_CYC)
                                                          : CNT_W'(`SWSS_STD_W1_LOW_CYC)) :
                     (fast_r ? CNT_W'(`SWSS_OD_RD_LOW_CYC) : CNT_W'(`SWSS_STD_RD_LOW_CYC));
    // Sample instant: presence after reset release, data late in the read window
    assign smp_at  = (kind_r == SWSS_SK_RESET) ? (fast_r ? OD_RST_SMP : STD_RST_SMP) :
                     (fast_r ? CNT_W'(`SWSS_OD_RD_SMP_CYC) : CNT_W'(`SWSS_STD_RD_SMP_CYC));
    // Whole slot plus recovery, or whole reset high window, before the next edge
    assign end_at  = (kind_r == SWSS_SK_RESET) ? (fast_r ? OD_RST_END : STD_RST_END)
                                               : (fast_r ? OD_SLT_END : STD_SLT_END);

    // Next state: the only falling edge made here is at slot start
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        oe_n_nxt  = oe_n_r;
        done_nxt  = 1'b0;
        bit_nxt   = bit_r;
        case (state_r)
            SL_IDLE: begin
                oe_n_nxt = 1'b1;                   // Idle high between slots
                if (i_start) begin
                    state_nxt = SL_BUSY;
                    cnt_nxt   = '0;
                    oe_n_nxt  = 1'b0;
                end
            end
            SL_BUSY: begin
                cnt_nxt  = cnt_r + CNT_W'(1);
                oe_n_nxt = (cnt_nxt >= low_end);   // Release after the low time
                if (cnt_r == smp_at) begin
                    bit_nxt = line_sync_r;         // Low here means zero or presence
                end
                if (cnt_nxt == end_at) begin
                    state_nxt = SL_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = SL_IDLE;
                oe_n_nxt  = 1'b1;
            end
        endcase
    end

    // Kind and speed are held for the whole waveform
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            kind_r <= SWSS_SK_RESET;
            fast_r <= 1'b0;
        end else if (state_r == SL_IDLE && i_start) begin
            kind_r <= i_kind;
            fast_r <= i_fast;
        end
    end

    // State, counter and registered outputs
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= SL_IDLE;
            cnt_r   <= '0;
            oe_n_r  <= 1'b1;
            done_r  <= 1'b0;
            bit_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            oe_n_r  <= oe_n_nxt;
            done_r  <= done_nxt;
            bit_r   <= bit_nxt;
        end
    end

    // Two-stage synchroniser on the line
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            line_meta_r <= 1'b1;
            line_sync_r <= 1'b1;
        end else begin
            line_meta_r <= i_line_in;
            line_sync_r <= line_meta_r;
        end
    end

    assign o_line_oe_n = oe_n_r;
    assign o_done      = done_r;
    assign o_bit       = bit_r;
endmodule // swss_slot
`default_nettype wire

// ===== swss_master_chk.sv
// Checker for swss_master: port relations of the line drive and the request handshake.
// Assumes one clock domain; it is attached by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module swss_master_chk #(
    parameter int STD_RST_LOW_CYC = 60000
) (
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    input wire logic       i_req_valid,
    input wire logic       o_req_ready,
    input wire logic       o_done,
    input wire logic       o_presence,
    input wire logic [7:0] o_rd_byte,
    input wire logic       o_overdrive,
    input wire logic       o_line_out,
    input wire logic       o_line_oe_n
);
    localparam int REC_MIN = 375;
    logic [17:0] low_r;
    logic [17:0] high_r;
    logic [17:0] low_nxt;
    logic [17:0] high_nxt;
    // Run lengths of the drive; high saturates so the first edge after reset passes
    assign low_nxt  = o_line_oe_n ? 18'h00000 : low_r + 18'h00001;
    assign high_nxt = !o_line_oe_n ? 18'h00000 : ((high_r == 18'h3FFFF) ? high_r : high_r + 18'h00001);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            low_r  <= 18'h00000;
            high_r <= 18'h3FFFF;
        end else begin
            low_r  <= low_nxt;
            high_r <= high_nxt;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_open_drain: assert property (o_line_out == 1'b0)
        else $error("line data not low");
    a_idle_no_pull: assert property (o_req_ready |-> o_line_oe_n)
        else $error("line pulled while idle");
    a_take_busy: assert property (i_req_valid && o_req_ready |=> !o_req_ready)
        else $error("request not taken");
    a_done_pulse: assert property (o_done |-> o_req_ready ##1 !o_done)
        else $error("done not a single pulse");
    a_speed_hold: assert property (o_req_ready && $past(o_req_ready) |-> $stable(o_overdrive))
        else $error("speed changed while idle");
    a_reset_len: assert property (low_r <= STD_RST_LOW_CYC + 4)
        else $error("low pulse too long");
    a_slot_recovery: assert property ($fell(o_line_oe_n) |-> high_r >= REC_MIN)
        else $error("recovery too short");
    a_presence_done: assert property ($changed(o_presence) |-> o_done)
        else $error("presence changed outside done");
    a_rdbyte_done: assert property ($changed(o_rd_byte) |-> o_done)
        else $error("read byte changed outside done");
endmodule // swss_master_chk
bind swss_master swss_master_chk #(.STD_RST_LOW_CYC(STD_RST_LOW_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .o_done(o_done), .o_presence(o_presence), .o_rd_byte(o_rd_byte), .o_overdrive(o_overdrive),
    .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n)
);
`default_nettype wire

// ===== swss_slave_model.sv
// Behavioural slave on the single wire: presence, bit decode, read drive, speed flag.
// Assumes the bench resolves the wire with a pull-up and feeds it back here.
`timescale 1ns/1ps
`default_nettype none
module swss_slave_model #(
    parameter int RST_MIN_CYC = 1500,
    parameter int CLR_CYC     = 8000,
    parameter int STD_THR     = 825,
    parameter int FAST_THR    = 500
) (
    input  wire logic       i_mclk,
    input  wire logic       i_line,
    input  wire logic       i_mute,
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_rd_byte,
    output logic            o_pull,
    output logic            o_od,
    output logic [7:0]      o_rx
);
    logic       prev_r = 1'b1;
    logic       own_r  = 1'b0;
    logic       first_r = 1'b0;
    logic [2:0] idx_r  = 3'h0;
    int         low_r  = 0;
    int         tmr_r  = 0;
    int         dly_r  = 0;
    int         nbits_r = 0;
    logic       bit_w;
    logic [7:0] rx_nxt;
    initial o_od = 1'b0;
    initial o_rx = 8'h00;
    // Short lows are a one; threshold follows the current speed
    assign bit_w  = low_r < (o_od ? FAST_THR : STD_THR);
    assign rx_nxt = {bit_w, o_rx[7:1]};
    assign o_pull = (tmr_r != 0) && (dly_r == 0);
    // Timing is taken from each falling edge; own presence edges are not slots
    always @(posedge i_mclk) begin
        prev_r <= i_line;
        if (!i_line) low_r <= low_r + 1;
        if (dly_r != 0) dly_r <= dly_r - 1;
        else if (tmr_r != 0) tmr_r <= tmr_r - 1;
        if (prev_r && !i_line) begin
            low_r <= 1;
            own_r <= o_pull;
            if (i_rd_en && !i_rd_byte[idx_r]) tmr_r <= o_od ? 400 : 1700;
            if (i_rd_en) idx_r <= idx_r + 3'h1;
        end
        if (!prev_r && i_line && !own_r) begin
            if (low_r >= CLR_CYC) o_od <= 1'b0;
            if (low_r >= RST_MIN_CYC) begin
                first_r <= 1'b1;
                nbits_r <= 0;
                idx_r   <= 3'h0;
                dly_r   <= i_mute ? 0 : 100;
                tmr_r   <= i_mute ? 0 : 1500;
            end else begin
                o_rx    <= rx_nxt;
                nbits_r <= nbits_r + 1;
                if (nbits_r % 8 == 7) first_r <= 1'b0;
                if (nbits_r == 7 && first_r && rx_nxt == 8'h3C) o_od <= 1'b1;
            end
        end
    end
endmodule // swss_slave_model
`default_nettype wire

// ===== swss_master_tb_top.sv
// Testbench: swss_master against the behavioural slave, shortened standard counts.
// Assumes the checker and slave model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "swss_regs.svh"
module swss_master_tb_top
    import swss_pkg::*;
();
    logic       mclk;
    logic       rstn;
    logic       req_valid;
    swss_op_t   req_op;
    logic [7:0] req_byte;
    logic       req_std;
    logic       ready;
    logic       done;
    logic       pres;
    logic [7:0] rd_byte;
    logic       od;
    logic       line_out;
    logic       oe_n;
    logic       line;
    logic       mute;
    logic       rd_en;
    logic       pull;
    logic       s_od;
    logic [7:0] s_rx;
    logic [7:0] rd_data;
    int         bad_count = 0;
    int         checked = 0;
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Open-drain wire with pull-up
    assign line = (oe_n ? 1'b1 : line_out) & ~pull;
    swss_master #(.STD_RST_LOW_CYC(9000), .STD_RST_HIGH_CYC(2000), .STD_PRES_SMP_CYC(1000),
        .STD_W0_LOW_CYC(900), .STD_SLOT_CYC(1000)) u_dut (
        .i_mclk(mclk), .i_rstn(rstn), .i_req_valid(req_valid), .i_req_op(req_op), .i_req_byte(req_byte),
        .i_req_rom({8{rd_data}}), .i_reset_std(req_std), .o_req_ready(ready), .o_done(done),
        .o_presence(pres), .o_rd_byte(rd_byte), .o_overdrive(od), .i_line_in(line), .o_line_out(line_out),
        .o_line_oe_n(oe_n));
    swss_slave_model u_slave (.i_mclk(mclk), .i_line(line), .i_mute(mute), .i_rd_en(rd_en),
        .i_rd_byte(rd_data), .o_pull(pull), .o_od(s_od), .o_rx(s_rx));
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // One request, held until the edge that takes it, then wait for done
    task automatic run_req(input swss_op_t op, input logic [7:0] data, input logic std);
        int n;
        @(negedge mclk);
        req_op    = op;
        req_byte  = data;
        req_std   = std;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_bit(done, 1'b1);
    endtask
    task automatic t_std_reset();
        run_req(SWSS_OP_RESET, 8'h00, 1'b0);
        chk_bit(pres, 1'b1);
        chk_bit(od, 1'b0);
        $display("test std_reset finished");
    endtask
    task automatic t_od_skip();
        run_req(SWSS_OP_OD_SKIP, 8'h00, 1'b0);
        chk_byte(s_rx, `SWSS_CMD_OD_SKIP);
        chk_bit(s_od, 1'b1);
        chk_bit(od, 1'b1);
        $display("test od_skip finished");
    endtask
    task automatic t_fast_reset();
        run_req(SWSS_OP_RESET, 8'h00, 1'b0);
        chk_bit(pres, 1'b1);
        chk_bit(s_od, 1'b1);
        chk_bit(od, 1'b1);
        $display("test fast_reset finished");
    endtask
    task automatic t_fast_write();
        run_req(SWSS_OP_WRITE_BYTE, 8'h5A, 1'b0);
        chk_byte(s_rx, 8'h5A);
        chk_bit(s_od, 1'b1);
        $display("test fast_write finished");
    endtask
    task automatic t_fast_read();
        rd_en = 1'b1;
        run_req(SWSS_OP_READ_BYTE, 8'h00, 1'b0);
        rd_en = 1'b0;
        chk_byte(rd_byte, 8'h96);
        $display("test fast_read finished");
    endtask
    task automatic t_std_mute();
        mute = 1'b1;
        run_req(SWSS_OP_RESET, 8'h00, 1'b1);
        chk_bit(pres, 1'b0);
        chk_bit(od, 1'b0);
        chk_bit(s_od, 1'b0);
        $display("test std_mute finished");
    endtask
    // Overdrive-match, cut short by a reset once the first identity bit is out
    task automatic t_od_match();
        int n;
        @(negedge mclk);
        req_op    = SWSS_OP_OD_MATCH;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        for (n = 0; od !== 1'b1 && n < 20000; n++) @(negedge mclk);
        chk_byte(s_rx, `SWSS_CMD_OD_MATCH);
        chk_bit(od, 1'b1);
        repeat (1200) @(negedge mclk);
        chk_byte(s_rx, {rd_data[0], 7'h34});
        rstn = 1'b0;
        @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        chk_bit(od, 1'b0);
        chk_byte(rd_byte, 8'h00);
        $display("test od_match finished");
    endtask
    task automatic tally_and_finish();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence; each test ends idle so the next may follow at once
    initial begin
        rstn      = 1'b0;
        req_valid = 1'b0;
        req_op    = SWSS_OP_RESET;
        req_byte  = 8'h00;
        req_std   = 1'b0;
        mute      = 1'b0;
        rd_en     = 1'b0;
        rd_data   = 8'h96;
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        t_std_reset();
        t_od_skip();
        t_fast_reset();
        t_fast_write();
        t_fast_read();
        t_std_mute();
        t_od_match();
        tally_and_finish();
    end
    // Watchdog: about one and a half times the expected run
    initial begin
        #1200000;
        bad_count++;
        tally_and_finish();
    end
endmodule // swss_master_tb_top
`default_nettype wire
